// *** sccs_pkg.sv ***
// constants, types and the three-stage input synchroniser of the sync, clamp, coast and clock-select block
// How it works
// - composite sync out follows green sync, uninverted
// - external clamp pin used only when enabled
// - otherwise clamp window counted from trailing edge
// - clamp polarity bit sets external clamp sense
// - coast freezes pixel clock frequency and phase
// - coast polarity bit sets coast input sense
// - coast polarity bit is one after reset
// - polarity one active high, zero active low
// - external clock select picks the external pixel clock
// - phase adjust still applies to external clock
// - hsync polarity picks leading edge, trailing clamps
package sccs_pkg;

  // ****************************************
  // configuration offsets and field positions
  // ****************************************
  localparam logic [7:0] SCCS_ADDR_SYNC        = 8'h0e;  // holds hsync polarity
  localparam logic [7:0] SCCS_ADDR_CLAMP       = 8'h0f;  // clamp and coast control
  localparam logic [7:0] SCCS_ADDR_MODE        = 8'h15;  // clock select
  localparam logic [7:0] SCCS_ADDR_CLAMP_START = 8'h05;  // clamp delay in pixels
  localparam logic [7:0] SCCS_ADDR_CLAMP_WIDTH = 8'h06;  // clamp duration in pixels

  localparam int SCCS_BIT_HSYNC_POL = 6;
  localparam int SCCS_BIT_EXT_CLAMP = 7;
  localparam int SCCS_BIT_CLAMP_POL = 6;
  localparam int SCCS_BIT_COAST_POL = 3;
  localparam int SCCS_BIT_EXT_CLK   = 0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic       SCCS_RST_HSYNC_POL   = 1'b0;
  localparam logic       SCCS_RST_EXT_CLAMP   = 1'b0;
  localparam logic       SCCS_RST_CLAMP_POL   = 1'b1;
  localparam logic       SCCS_RST_COAST_POL   = 1'b1;
  localparam logic       SCCS_RST_EXT_CLK     = 1'b0;
  localparam logic [7:0] SCCS_RST_CLAMP_START = 8'h08;
  localparam logic [7:0] SCCS_RST_CLAMP_WIDTH = 8'h14;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic       hsyncPol;
    logic       extClampEn;
    logic       clampPol;
    logic       coastPol;
    logic       extClkSel;
    logic [7:0] clampStart;
    logic [7:0] clampWidth;
  } sccs_cfg_t;

  localparam sccs_cfg_t SCCS_CFG_RESET = '{
    hsyncPol:   SCCS_RST_HSYNC_POL,
    extClampEn: SCCS_RST_EXT_CLAMP,
    clampPol:   SCCS_RST_CLAMP_POL,
    coastPol:   SCCS_RST_COAST_POL,
    extClkSel:  SCCS_RST_EXT_CLK,
    clampStart: SCCS_RST_CLAMP_START,
    clampWidth: SCCS_RST_CLAMP_WIDTH
  };

  // internal clamp window states, gray along idle, delay, active
  typedef enum logic [1:0] {
    SCCS_CL_IDLE   = 2'b00,
    SCCS_CL_DELAY  = 2'b01,
    SCCS_CL_ACTIVE = 2'b11
  } sccs_clamp_state_t;

endpackage

// three flip-flops; the level moves only once the second and third agree
module sccs_sync3 (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic pinIn,
  output logic      level
);

  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       next_level;

  // shift the pin in and update the filtered level on agreement
  always_comb begin
    next_stage = {stage[1:0], pinIn};
    next_level = (stage[1] == stage[2]) ? stage[2] : level;
  end

  // register the chain; in reset it keeps flushing so the level starts at the pin's idle value
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stage <= next_stage;
      level <= stage[1];  // no false edge once reset lifts
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end

endmodule

// *** sccs_top.sv ***
// sync, clamp, coast and pixel clock selection logic of the video digitizer front end
module sccs_top
  import sccs_pkg::*;
#(
  parameter int PHASE_W = 16,  // pixel clock phase accumulator width
  parameter int DLY_W   = 3    // sampling phase adjust select width
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  input  wire logic               horizontal_sync_in_ch0,
  input  wire logic               horizontal_sync_in_ch1,
  input  wire logic               green_embedded_sync_in_ch0,
  input  wire logic               green_embedded_sync_in_ch1,
  input  wire logic               clampIn,
  input  wire logic               coastIn,
  input  wire logic               external_pixel_clock_in,
  input  wire logic               chanSel,
  input  wire logic               cfgWrite,
  input  wire logic [7:0]         cfgAddr,
  input  wire logic [7:0]         cfgData,
  input  wire logic [PHASE_W-1:0] pllFreqWord,
  input  wire logic [DLY_W-1:0]   phaseAdj,
  output logic                    composite_sync_out,
  output logic                    clampOut,
  output logic                    coastActive,
  output logic                    pixelClkOut,
  output logic                    sampleTick,
  output sccs_cfg_t               cfgState
);

  localparam int NPIN  = 7;
  localparam int DLY_D = 2 ** DLY_W;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] pinLvl;

  assign pinRaw = {external_pixel_clock_in, coastIn, clampIn,
                   green_embedded_sync_in_ch1, green_embedded_sync_in_ch0,
                   horizontal_sync_in_ch1, horizontal_sync_in_ch0};

  // one filter per asynchronous pin
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : gSync
      sccs_sync3 sccs_sync3_i (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .pinIn   (pinRaw[gi]),
        .level   (pinLvl[gi])
      );
    end
  endgenerate

  logic hsSel;
  logic sogSel;
  logic clampLvl;
  logic coastLvl;
  logic extClkLvl;

  // channel mux after filtering, both channels stay in one domain
  assign hsSel     = chanSel ? pinLvl[1] : pinLvl[0];
  assign sogSel    = chanSel ? pinLvl[3] : pinLvl[2];
  assign clampLvl  = pinLvl[4];
  assign coastLvl  = pinLvl[5];
  assign extClkLvl = pinLvl[6];

  // ****************************************
  // configuration bits
  // ****************************************
  sccs_cfg_t cfg;
  sccs_cfg_t next_cfg;

  // decode writes into the control copies
  always_comb begin
    next_cfg = cfg;
    if (cfgWrite) begin
      case (cfgAddr)
        SCCS_ADDR_SYNC: begin
          next_cfg.hsyncPol = cfgData[SCCS_BIT_HSYNC_POL];
        end
        SCCS_ADDR_CLAMP: begin
          next_cfg.extClampEn = cfgData[SCCS_BIT_EXT_CLAMP];
          next_cfg.clampPol   = cfgData[SCCS_BIT_CLAMP_POL];
          next_cfg.coastPol   = cfgData[SCCS_BIT_COAST_POL];
        end
        SCCS_ADDR_MODE: begin
          next_cfg.extClkSel = cfgData[SCCS_BIT_EXT_CLK];  // software keeps it low unless driven
        end
        SCCS_ADDR_CLAMP_START: begin
          next_cfg.clampStart = cfgData;
        end
        SCCS_ADDR_CLAMP_WIDTH: begin
          next_cfg.clampWidth = cfgData;
        end
        default: begin
          next_cfg = cfg;
        end
      endcase
    end
  end

  // reset leaves external clamp off and coast active high
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cfg <= SCCS_CFG_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  assign cfgState = cfg;

  // ****************************************
  // hsync edges and coast
  // ****************************************
  logic hsPrev;
  logic hsRise;
  logic hsFall;
  logic hsLead;
  logic hsTrail;
  logic next_coastActive;

  assign hsRise  = hsSel & ~hsPrev;
  assign hsFall  = ~hsSel & hsPrev;
  assign hsLead  = cfg.hsyncPol ? hsRise : hsFall;
  assign hsTrail = cfg.hsyncPol ? hsFall : hsRise;

  // coast is active when the pin matches the polarity bit
  always_comb begin
    next_coastActive = (coastLvl == cfg.coastPol);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      hsPrev      <= hsSel;  // track the idle level so release shows no edge
      coastActive <= 1'b0;
    end else begin
      hsPrev      <= hsSel;
      coastActive <= next_coastActive;
    end
  end

  // ****************************************
  // pixel clock generation and selection
  // ****************************************
  logic [PHASE_W-1:0] phaseAcc;
  logic [PHASE_W-1:0] next_phaseAcc;
  logic [DLY_D-1:0]   lvlLine;
  logic [DLY_D-1:0]   next_lvlLine;
  logic               selLvl;
  logic               tap;
  logic               next_pixelClk;
  logic               next_sampleTick;

  // accumulator realigns on the leading edge unless coasting
  always_comb begin
    if (hsLead && !coastActive) begin
      next_phaseAcc = '0;
    end else begin
      next_phaseAcc = phaseAcc + pllFreqWord;  // free run keeps rate and phase
    end
  end

  // choose the clock source, then delay it by the phase adjust
  assign selLvl = cfg.extClkSel ? extClkLvl : phaseAcc[PHASE_W-1];
  assign tap    = lvlLine[phaseAdj];  // changing the tap mid-line may slip a pixel

  always_comb begin
    next_lvlLine    = {lvlLine[DLY_D-2:0], selLvl};
    next_pixelClk   = tap;
    next_sampleTick = tap & ~pixelClkOut;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      phaseAcc    <= '0;
      lvlLine     <= '0;
      pixelClkOut <= 1'b0;
      sampleTick  <= 1'b0;
    end else begin
      phaseAcc    <= next_phaseAcc;
      lvlLine     <= next_lvlLine;
      pixelClkOut <= next_pixelClk;
      sampleTick  <= next_sampleTick;
    end
  end

  // ****************************************
  // internal clamp window
  // ****************************************
  sccs_clamp_state_t clampState;
  sccs_clamp_state_t next_clampState;
  logic [7:0]        clampCnt;
  logic [7:0]        next_clampCnt;

  // a trailing edge always restarts the delay count
  always_comb begin
    next_clampState = clampState;
    next_clampCnt   = clampCnt;
    if (hsTrail) begin
      next_clampState = SCCS_CL_DELAY;
      next_clampCnt   = 8'h00;
    end else begin
      case (clampState)
        SCCS_CL_IDLE: begin
          next_clampCnt = 8'h00;
        end
        SCCS_CL_DELAY: begin
          if (clampCnt >= cfg.clampStart) begin
            next_clampState = (cfg.clampWidth == 8'h00) ? SCCS_CL_IDLE : SCCS_CL_ACTIVE;
            next_clampCnt   = 8'h00;
          end else if (sampleTick) begin
            next_clampCnt = 8'(clampCnt + 8'h01);
          end
        end
        SCCS_CL_ACTIVE: begin
          if (sampleTick) begin
            if (8'(clampCnt + 8'h01) >= cfg.clampWidth) begin
              next_clampState = SCCS_CL_IDLE;
              next_clampCnt   = 8'h00;
            end else begin
              next_clampCnt = 8'(clampCnt + 8'h01);
            end
          end
        end
        default: begin
          next_clampState = SCCS_CL_IDLE;
          next_clampCnt   = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      clampState <= SCCS_CL_IDLE;
      clampCnt   <= 8'h00;
    end else begin
      clampState <= next_clampState;
      clampCnt   <= next_clampCnt;
    end
  end

  // ****************************************
  // clamp and composite sync outputs
  // ****************************************
  logic next_clampOut;
  logic next_csync;

  // external pin only when enabled, else the counted window
  always_comb begin
    if (cfg.extClampEn) begin
      next_clampOut = (clampLvl == cfg.clampPol);
    end else begin
      next_clampOut = (clampState == SCCS_CL_ACTIVE);
    end
    next_csync = sogSel;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      clampOut           <= 1'b0;
      composite_sync_out <= 1'b0;
    end else begin
      clampOut           <= next_clampOut;
      composite_sync_out <= next_csync;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cbDef @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  chk_csync_sense: assert property (sogSel |=> composite_sync_out)
    else $error("composite sync does not follow green sync");

  chk_clamp_gated: assert property ((!cfg.extClampEn && clampState != SCCS_CL_ACTIVE) |=> !clampOut)
    else $error("clamp asserted without enable or window");

  chk_clamp_window: assert property ((!cfg.extClampEn && hsTrail) |=> clampState == SCCS_CL_DELAY)
    else $error("trailing edge did not start the clamp delay");

  chk_clamp_polarity: assert property ((cfg.extClampEn && clampLvl != cfg.clampPol) |=> !clampOut)
    else $error("external clamp sense wrong");

  chk_coast_hold: assert property (coastActive |=> phaseAcc == PHASE_W'($past(phaseAcc) + $past(pllFreqWord)))
    else $error("accumulator resynced while coasting");

  chk_coast_sense: assert property ((coastLvl != cfg.coastPol) ##1 (coastLvl != cfg.coastPol) |=> !coastActive)
    else $error("coast active against polarity");

  chk_coast_reset: assert property (@(posedge ref_clk) disable iff (1'b0) $rose(rst_b) |-> cfg.coastPol)
    else $error("coast polarity not one after reset");

  chk_ext_clock: assert property (cfg.extClkSel |=> lvlLine[0] == $past(extClkLvl))
    else $error("external clock not selected");

  chk_phase_tick: assert property ((($rose(selLvl) && phaseAdj == '0) ##1 (phaseAdj == '0)) |=> sampleTick)
    else $error("sample tick late for phase zero");

  chk_lead_align: assert property ((hsLead && !coastActive) |=> phaseAcc == '0)
    else $error("leading edge did not realign phase");

  cov_coast_run: cover property (coastActive [*4] ##1 !coastActive);
  cov_int_clamp: cover property (clampState == SCCS_CL_DELAY ##[1:600] clampState == SCCS_CL_ACTIVE);
  cov_ext_clamp: cover property (cfg.extClampEn && clampOut);
  cov_ext_clock: cover property (cfg.extClkSel && sampleTick);

endmodule

// *** sccs_top_bench.sv ***
// self-checking bench for the sync, clamp, coast and pixel clock selection block
module sccs_top_bench
  import sccs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst_b, chanSel, cfgWrite;
  logic [7:0]  cfgAddr, cfgData;
  logic [15:0] pllFreqWord;
  logic [2:0]  phaseAdj;
  logic        lineRun, horizontal_sync_polarity, clampReq, clampPol, coastReq, coastPol, extRun;
  logic        hs0, hs1, gr0, gr1, clampPin, coastPin, extClk;
  logic        compSync, clampOut, coastActive, pixelClkOut, sampleTick;
  sccs_cfg_t   cfgState;
  int          fails = 0;
  int          checked = 0;

  // clock at 250 MHz
  always #2 ref_clk = ~ref_clk;

  sccs_top #(.PHASE_W(16), .DLY_W(3)) sccs_top_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .horizontal_sync_in_ch0(hs0), .horizontal_sync_in_ch1(hs1),
    .green_embedded_sync_in_ch0(gr0), .green_embedded_sync_in_ch1(gr1), .clampIn(clampPin),
    .coastIn(coastPin), .external_pixel_clock_in(extClk), .chanSel(chanSel), .cfgWrite(cfgWrite),
    .cfgAddr(cfgAddr), .cfgData(cfgData), .pllFreqWord(pllFreqWord), .phaseAdj(phaseAdj),
    .composite_sync_out(compSync), .clampOut(clampOut), .coastActive(coastActive),
    .pixelClkOut(pixelClkOut), .sampleTick(sampleTick), .cfgState(cfgState));

  sccs_video_src sccs_video_src_i (
    .ref_clk(ref_clk), .lineRun(lineRun), .horizontal_sync_polarity(horizontal_sync_polarity), .clampReq(clampReq), .clampPol(clampPol),
    .coastReq(coastReq), .coastPol(coastPol), .extRun(extRun), .hs0(hs0), .hs1(hs1), .gr0(gr0),
    .gr1(gr1), .clampPin(clampPin), .coastPin(coastPin), .extClk(extClk));

  // pin selector for the bounded waits
  function automatic logic pin(input int which);
    case (which)
      0: return hs0;
      1: return extClk;
      2: return clampOut;
      3: return gr0;
      default: return sampleTick;
    endcase
  endfunction

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wait_pin(input int which, input logic lvl, output int n);
    n = 0;
    while (pin(which) !== lvl && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 300) begin
      fails++;
      $display("ERROR at %0t: pin %0d stuck", $time, which);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: %s", $time, what);
    end
  endtask

  task automatic check_range(input int got, input int lo, input int hi, input string what);
    checked++;
    if (got < lo || got > hi) begin
      fails++;
      $display("ERROR at %0t: %s (%0d)", $time, what, got);
    end
  endtask

  task automatic check_cfg(input sccs_cfg_t got, input sccs_cfg_t exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: configuration state wrong", $time);
    end
  endtask

  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    cfgWrite = 1'b1;
    cfgAddr = a;
    cfgData = d;
    @(negedge ref_clk);
    cfgWrite = 1'b0;
  endtask

  task automatic test_reset;
    sccs_cfg_t exp;
    idle(6);
    check_cfg(cfgState, SCCS_CFG_RESET);
    check_bit(coastActive, 1'b0, "coast active with low pin");
    cfg_write(SCCS_ADDR_CLAMP, 8'h80);
    cfg_write(8'h33, 8'hff);
    exp = SCCS_CFG_RESET;
    exp.extClampEn = 1'b1;
    exp.clampPol = 1'b0;
    exp.coastPol = 1'b0;
    check_cfg(cfgState, exp);
    $display("test reset done");
  endtask

  task automatic test_green;
    int n;
    lineRun = 1'b1;
    wait_pin(3, 1'b0, n);
    idle(6);
    check_bit(compSync, 1'b0, "composite sync not low in sync tip");
    wait_pin(3, 1'b1, n);
    idle(6);
    check_bit(compSync, 1'b1, "composite sync not high after tip");
    chanSel = 1'b1;
    wait_pin(3, 1'b0, n);
    idle(6);
    check_bit(compSync, 1'b1, "channel one green not selected");
    chanSel = 1'b0;
    $display("test green sync done");
  endtask

  task automatic test_coast;
    for (int p = 0; p < 2; p++)
      for (int r = 0; r < 2; r++) begin
        cfg_write(SCCS_ADDR_CLAMP, p[0] ? 8'h08 : 8'h00);
        coastPol = p[0];
        coastReq = r[0];
        idle(6);
        check_bit(coastActive, r[0], "coast state wrong");
      end
    coastReq = 1'b0;
    $display("test coast done");
  endtask

  task automatic test_ext_clamp;
    lineRun = 1'b0;
    clampReq = 1'b1;
    clampPol = 1'b1;
    cfg_write(SCCS_ADDR_CLAMP, 8'h48);
    idle(150);
    check_bit(clampOut, 1'b0, "clamp pin honoured while disabled");
    for (int p = 0; p < 2; p++)
      for (int r = 0; r < 2; r++) begin
        cfg_write(SCCS_ADDR_CLAMP, {1'b1, p[0], 6'h08});
        clampPol = p[0];
        clampReq = r[0];
        idle(6);
        check_bit(clampOut, r[0], "external clamp sense wrong");
      end
    $display("test external clamp done");
  endtask

  task automatic test_int_clamp;
    int n;
    cfg_write(SCCS_ADDR_CLAMP, 8'h48);
    cfg_write(SCCS_ADDR_CLAMP_START, 8'h02);
    cfg_write(SCCS_ADDR_CLAMP_WIDTH, 8'h05);
    clampReq = 1'b1;  // pin raised in the porch but disabled
    lineRun = 1'b1;
    wait_pin(0, horizontal_sync_polarity, n);
    wait_pin(0, ~horizontal_sync_polarity, n);
    wait_pin(2, 1'b1, n);
    check_range(n, 6, 22, "clamp delay off");
    wait_pin(2, 1'b0, n);
    check_range(n, 16, 24, "clamp width off");
    cfg_write(SCCS_ADDR_CLAMP_WIDTH, 8'h00);
    n = 0;
    repeat (140) begin
      @(negedge ref_clk);
      if (clampOut !== 1'b0) n++;
    end
    check_range(n, 0, 0, "clamp window with zero width");
    clampReq = 1'b0;
    $display("test internal clamp done");
  endtask

  task automatic test_phase_lock;
    int a, b, n;
    for (int p = 0; p < 3; p++) begin
      horizontal_sync_polarity = p[0];
      cfg_write(SCCS_ADDR_SYNC, {1'b0, p[0], 6'h00});
      coastReq = (p == 2);
      idle(140);
      wait_pin(0, ~horizontal_sync_polarity, n);
      wait_pin(0, horizontal_sync_polarity, n);
      wait_pin(4, 1'b1, a);
      wait_pin(0, ~horizontal_sync_polarity, n);
      wait_pin(0, horizontal_sync_polarity, n);
      wait_pin(4, 1'b1, b);
      check_range((b - a + 4) % 4, (p == 2) ? 2 : 0, (p == 2) ? 2 : 0, "tick phase vs leading edge");
    end
    coastReq = 1'b0;
    $display("test phase lock done");
  endtask

  task automatic test_ext_clock;
    int a, b, n;
    lineRun = 1'b0;
    extRun = 1'b1;
    cfg_write(SCCS_ADDR_MODE, 8'h01);
    idle(20);
    n = 0;
    repeat (64) begin
      @(negedge ref_clk);
      if (sampleTick === 1'b1) n++;
    end
    check_range(n, 8, 8, "ticks not from external clock");
    wait_pin(1, 1'b0, n);
    wait_pin(1, 1'b1, n);
    wait_pin(4, 1'b1, a);
    check_bit(pixelClkOut, 1'b1, "pixel clock not high with its tick");
    idle(4);
    check_bit(pixelClkOut, 1'b0, "pixel clock not low half a period on");
    phaseAdj = 3'h3;
    idle(20);
    wait_pin(1, 1'b0, n);
    wait_pin(1, 1'b1, n);
    wait_pin(4, 1'b1, b);
    check_range((b - a + 8) % 8, 3, 3, "phase adjust lost on external clock");
    phaseAdj = 3'h0;
    cfg_write(SCCS_ADDR_MODE, 8'h00);
    extRun = 1'b0;
    $display("test external clock done");
  endtask

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // main sequence
  initial begin
    rst_b = 1'b0;
    chanSel = 1'b0;
    cfgWrite = 1'b0;
    cfgAddr = 8'h00;
    cfgData = 8'h00;
    pllFreqWord = 16'h4000;
    phaseAdj = 3'h0;
    {lineRun, horizontal_sync_polarity, clampReq, clampPol, coastReq, extRun} = 6'h00;
    coastPol = 1'b1;
    idle(4);
    rst_b = 1'b1;
    test_reset();
    test_green();
    test_coast();
    test_ext_clamp();
    test_int_clamp();
    test_phase_lock();
    test_ext_clock();
    print_verdict();
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end
endmodule

// *** sccs_video_src.sv ***
// video source and sync timing model driving the sync, clamp, coast and external clock pins
module sccs_video_src (
  input  wire logic ref_clk,
  input  wire logic lineRun,
  input  wire logic horizontal_sync_polarity,
  input  wire logic clampReq,
  input  wire logic clampPol,
  input  wire logic coastReq,
  input  wire logic coastPol,
  input  wire logic extRun,
  output logic      hs0,
  output logic      hs1,
  output logic      gr0,
  output logic      gr1,
  output logic      clampPin,
  output logic      coastPin,
  output logic      extClk
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LINE = 66;  // not a multiple of the pixel period, so a free clock drifts
  localparam int SYNC = 8;
  int   lineCnt = 0;
  int   extCnt  = 0;
  logic inSync;
  logic porch;
  // line and external clock counters, pins move on the falling edge
  always @(negedge ref_clk) begin
    lineCnt <= lineRun ? (lineCnt + 1) % LINE : 0;
    extCnt  <= (extCnt + 1) % 8;
  end
  // pin levels; the stopped external clock rests low on its pull-down
  assign inSync   = lineRun && (lineCnt < SYNC);
  assign porch    = !lineRun || (lineCnt >= SYNC && lineCnt < SYNC + 6);
  assign hs0      = inSync ~^ horizontal_sync_polarity;
  assign hs1      = 1'b1;
  assign gr0      = !inSync;
  assign gr1      = 1'b1;
  assign clampPin = (clampReq && porch) ~^ clampPol;
  assign coastPin = coastReq ~^ coastPol;
  assign extClk   = extRun && (extCnt < 4);
endmodule
